//--- common/srs_pkg.sv
package srs_pkg;
   // Register map, byte addresses on a 32-bit AXI4-Lite slave
   localparam logic [7:0]  OFF_TX_CFG     = 8'h00;
   localparam logic [7:0]  OFF_CHANNEL_PLL_CFG   = 8'h04;
   localparam logic [7:0]  OFF_QPLLA_CFG  = 8'h08;
   localparam logic [7:0]  OFF_QPLLB_CFG  = 8'h0c;
   localparam logic [7:0]  OFF_STATUS     = 8'h10;
   // Fields of the tx configuration word, and the width of the pll duration fields
   localparam int          TX_PMA_DUR_LSB = 0;
   localparam int          TX_PCS_DUR_LSB = 8;
   localparam int          RX_DUR_LSB     = 16;
   localparam int          TXRX_DUR_W     = 5;
   localparam int          PLL_DUR_W      = 10;
   // Values after reset
   localparam logic [4:0]  TX_PMA_DUR_RST = 5'h04;
   localparam logic [4:0]  TX_PCS_DUR_RST = 5'h04;
   localparam logic [4:0]  RX_DUR_RST     = 5'h04;
   localparam logic [9:0]  PLL_DUR_RST    = 10'h010;
   // Status word bit positions
   localparam int          ST_CHANNEL_PLL_LOCK   = 0;
   localparam int          ST_QPLLA_LOCK  = 1;
   localparam int          ST_QPLLB_LOCK  = 2;
   localparam int          ST_TX_DONE     = 3;
   localparam int          ST_TX_PMA_DONE = 4;
   localparam int          ST_RX_DONE     = 5;
   localparam int          ST_TX_STATE    = 8;
   // One duration tick is 2**DUR_SHIFT clock cycles
   localparam int          DUR_SHIFT      = 2;
   localparam int          CNT_W          = 16;
   // Lock acquisition time after the internal pll reset ends
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          LOCK_TIME_NS   = 1000;
   localparam logic [15:0] LOCK_CYCLES    = 16'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_HOLD = 3'h1,
      TX_PMA  = 3'h2,
      TX_WRDY = 3'h3,
      TX_PCS  = 3'h4
   } srs_tx_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_HOLD = 2'h1,
      RX_PMA  = 2'h2,
      RX_PCS  = 2'h3
   } srs_rx_e;

   typedef enum logic [1:0] {
      PLL_HOLD = 2'h0,
      PLL_RST  = 2'h1,
      PLL_ACQ  = 2'h2,
      PLL_LOCK = 2'h3
   } srs_pll_e;
endpackage

//--- src/srs_pll_ctl.sv
`timescale 1ns/10ps
module srs_pll_ctl (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       pll_reset,
   input  wire logic       lock_detect_en,
   input  wire logic [9:0] reset_duration,
   output logic            locked
);
   logic                   rq1_r;
   logic                   rq2_r;
   logic                   en1_r;
   logic                   en2_r;
   srs_pkg::srs_pll_e      st_r;
   logic [15:0]            cnt_r;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rq1_r <= 1'b0;
         rq2_r <= 1'b0;
         en1_r <= 1'b0;
         en2_r <= 1'b0;
      end else begin
         rq1_r <= pll_reset;
         rq2_r <= rq1_r;
         en1_r <= lock_detect_en;
         en2_r <= en1_r;
      end
   end

   // Power-up counts as a reset request, so the pll starts unlocked
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r  <= srs_pkg::PLL_HOLD;
         cnt_r <= 16'h0000;
      end else if (rq2_r) begin
         st_r  <= srs_pkg::PLL_HOLD;
         cnt_r <= 16'h0000;
      end else begin
         unique case (st_r)
            srs_pkg::PLL_HOLD: begin
               st_r  <= srs_pkg::PLL_RST;
               cnt_r <= 16'({reset_duration, 2'h0});
            end
            srs_pkg::PLL_RST: begin
               if (cnt_r == 16'h0000) begin
                  st_r  <= srs_pkg::PLL_ACQ;
                  cnt_r <= srs_pkg::LOCK_CYCLES;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            srs_pkg::PLL_ACQ: begin
               if (cnt_r == 16'h0000) begin
                  st_r <= srs_pkg::PLL_LOCK;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            srs_pkg::PLL_LOCK: begin
               st_r <= srs_pkg::PLL_LOCK;
            end
         endcase
      end
   end

   // Lock is only reported while the detector is enabled
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         locked <= 1'b0;
      end else begin
         locked <= (st_r == srs_pkg::PLL_LOCK) && en2_r && !rq2_r;
      end
   end

   property p_pll_lock_low_in_reset;
      @(posedge mclk) disable iff (!rst_b)
      rq2_r |=> !locked;
   endproperty
   a_pll_lock_low_in_reset: assert property (p_pll_lock_low_in_reset)
      else $error("pll lock shown during reset");

   property p_pll_reset_long;
      @(posedge mclk) disable iff (!rst_b)
      $fell(rq2_r) |-> !locked [*4];
   endproperty
   a_pll_reset_long: assert property (p_pll_reset_long)
      else $error("pll locked too soon after reset pulse");
endmodule

//--- src/srs_sequencer.sv
`timescale 1ns/10ps
// Functional notes
// - Pll resets run independently of tx/rx resets and of reset mode.
// - Any reset input high starts the sequencer and holds it in reset.
// - Rx resets support sequential and single mode; tx only sequential.
// - Sequential mode runs all later states, then raises reset-complete.
// - Single mode runs only the requested rx region for its duration.
// - Mode select low gives sequential, high gives single; override low.
// - A pll reset pulse starts a much longer internal reset; lock marks end.
// - Pll lock is active high, asserted only when frequency is in tolerance.
// - Per-pll lock-detect enable switches its lock detection on.
// - Channel pll reset duration is a non-zero 10-bit value.
// - Two quad plls behave like the channel pll with own durations.
// - Tx full reset runs a complete pma then pcs reset sequence.
// - Tx pcs reset does not start until tx user ready is high.
// - Analog reset does pma then pcs; coding reset pcs only; start on release.
// - Tx reset-complete drops on full reset, rises after ready and sequence end.
// - Analog reset-complete drops on full or analog reset, rises after pma.
// - Tx pma and pcs durations are 5-bit, non-zero when used.
module srs_sequencer (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        channel_pll_reset,
   input  wire logic        channel_pll_lock_detect_en,
   output logic             channel_pll_locked,
   input  wire logic        quad_pll_a_reset,
   input  wire logic        quad_pll_a_lock_detect_en,
   output logic             quad_pll_a_locked,
   input  wire logic        quad_pll_b_reset,
   input  wire logic        quad_pll_b_lock_detect_en,
   output logic             quad_pll_b_locked,
   input  wire logic        reset_sequence_select,
   input  wire logic        reset_override,
   input  wire logic        tx_full_reset,
   input  wire logic        tx_analog_region_reset,
   input  wire logic        tx_coding_region_reset,
   input  wire logic        tx_user_ready,
   output logic             tx_reset_complete,
   output logic             tx_analog_reset_complete,
   input  wire logic        rx_full_reset,
   output logic             rx_reset_complete
);
   logic [6:0]              sy1_r;
   logic [6:0]              sy2_r;
   logic                    full_s;
   logic                    pma_s;
   logic                    pcs_s;
   logic                    rdy_s;
   logic                    rxr_s;
   logic                    single_s;
   logic                    ovrd_s;
   logic                    tx_any_s;
   logic [31:0]             tx_cfg_r;
   logic [9:0]              channel_pll_dur_r;
   logic [9:0]              qa_dur_r;
   logic [9:0]              qb_dur_r;
   logic [31:0]             wmask;
   logic                    wr_go;
   srs_pkg::srs_tx_e        tx_st_r;
   logic                    tx_from_pcs_r;
   logic [15:0]             tx_cnt_r;
   srs_pkg::srs_rx_e        rx_st_r;
   logic                    rx_single_r;
   logic [15:0]             rx_cnt_r;

   // Every reset, mode, override and ready pin passes two flops before any logic reads it; AXI inputs are read directly
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sy1_r <= 7'h00;
         sy2_r <= 7'h00;
      end else begin
         sy1_r <= {reset_override, reset_sequence_select, rx_full_reset, tx_user_ready,
                   tx_coding_region_reset, tx_analog_region_reset, tx_full_reset};
         sy2_r <= sy1_r;
      end
   end

   assign full_s   = sy2_r[0];
   assign pma_s    = sy2_r[1];
   assign pcs_s    = sy2_r[2];
   assign rdy_s    = sy2_r[3];
   assign rxr_s    = sy2_r[4];
   assign single_s = sy2_r[5];
   assign ovrd_s   = sy2_r[6];
   // Override is reserved; while it is high the sequencers ignore requests
   assign tx_any_s = !ovrd_s && (full_s || pma_s || pcs_s);

   // Pll controls see neither tx/rx resets nor the mode select
   srs_pll_ctl u_channel_pll (
      .mclk           (mclk),
      .rst_b          (rst_b),
      .pll_reset      (channel_pll_reset),
      .lock_detect_en (channel_pll_lock_detect_en),
      .reset_duration (channel_pll_dur_r),
      .locked         (channel_pll_locked)
   );

   srs_pll_ctl u_qplla (
      .mclk           (mclk),
      .rst_b          (rst_b),
      .pll_reset      (quad_pll_a_reset),
      .lock_detect_en (quad_pll_a_lock_detect_en),
      .reset_duration (qa_dur_r),
      .locked         (quad_pll_a_locked)
   );

   srs_pll_ctl u_qpllb (
      .mclk           (mclk),
      .rst_b          (rst_b),
      .pll_reset      (quad_pll_b_reset),
      .lock_detect_en (quad_pll_b_lock_detect_en),
      .reset_duration (qb_dur_r),
      .locked         (quad_pll_b_locked)
   );

   // Write address and data are taken together, one write at a time
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_cfg_r   <= {11'h000, srs_pkg::RX_DUR_RST, 3'h0, srs_pkg::TX_PCS_DUR_RST,
                        3'h0, srs_pkg::TX_PMA_DUR_RST};
         channel_pll_dur_r <= srs_pkg::PLL_DUR_RST;
         qa_dur_r   <= srs_pkg::PLL_DUR_RST;
         qb_dur_r   <= srs_pkg::PLL_DUR_RST;
      end else if (wr_go) begin
         unique case (s_axi_awaddr)
            srs_pkg::OFF_TX_CFG:    tx_cfg_r   <= ((tx_cfg_r & ~wmask) | (s_axi_wdata & wmask)) & 32'h001f1f1f;
            srs_pkg::OFF_CHANNEL_PLL_CFG:  channel_pll_dur_r <= 10'((32'(channel_pll_dur_r) & ~wmask) | (s_axi_wdata & wmask));
            srs_pkg::OFF_QPLLA_CFG: qa_dur_r   <= 10'((32'(qa_dur_r) & ~wmask) | (s_axi_wdata & wmask));
            srs_pkg::OFF_QPLLB_CFG: qb_dur_r   <= 10'((32'(qb_dur_r) & ~wmask) | (s_axi_wdata & wmask));
            default:                tx_cfg_r   <= tx_cfg_r;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= srs_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (s_axi_awaddr == srs_pkg::OFF_TX_CFG || s_axi_awaddr == srs_pkg::OFF_CHANNEL_PLL_CFG ||
                          s_axi_awaddr == srs_pkg::OFF_QPLLA_CFG || s_axi_awaddr == srs_pkg::OFF_QPLLB_CFG) ?
                         srs_pkg::RESP_OKAY : srs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= srs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= srs_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            srs_pkg::OFF_TX_CFG:    s_axi_rdata <= tx_cfg_r;
            srs_pkg::OFF_CHANNEL_PLL_CFG:  s_axi_rdata <= {22'h000000, channel_pll_dur_r};
            srs_pkg::OFF_QPLLA_CFG: s_axi_rdata <= {22'h000000, qa_dur_r};
            srs_pkg::OFF_QPLLB_CFG: s_axi_rdata <= {22'h000000, qb_dur_r};
            srs_pkg::OFF_STATUS: begin
               s_axi_rdata <= {21'h000000, tx_st_r, 2'h0, rx_reset_complete, tx_analog_reset_complete,
                               tx_reset_complete, quad_pll_b_locked, quad_pll_a_locked, channel_pll_locked};
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= srs_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Tx ignores the mode select: it always runs sequentially
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_st_r       <= srs_pkg::TX_HOLD;
         tx_from_pcs_r <= 1'b0;
         tx_cnt_r      <= 16'h0000;
      end else if (tx_any_s) begin
         tx_st_r       <= srs_pkg::TX_HOLD;
         tx_from_pcs_r <= pcs_s && !full_s && !pma_s;
         tx_cnt_r      <= 16'h0000;
      end else begin
         unique case (tx_st_r)
            srs_pkg::TX_IDLE: tx_st_r <= srs_pkg::TX_IDLE;
            srs_pkg::TX_HOLD: begin
               // Release of the request starts the sequence
               if (tx_from_pcs_r) begin
                  tx_st_r <= srs_pkg::TX_WRDY;
               end else begin
                  tx_st_r  <= srs_pkg::TX_PMA;
                  tx_cnt_r <= 16'({tx_cfg_r[srs_pkg::TX_PMA_DUR_LSB +: srs_pkg::TXRX_DUR_W], 2'h0});
               end
            end
            srs_pkg::TX_PMA: begin
               if (tx_cnt_r == 16'h0000) begin
                  tx_st_r <= srs_pkg::TX_WRDY;
               end else begin
                  tx_cnt_r <= tx_cnt_r - 16'h0001;
               end
            end
            srs_pkg::TX_WRDY: begin
               if (rdy_s) begin
                  tx_st_r  <= srs_pkg::TX_PCS;
                  tx_cnt_r <= 16'({tx_cfg_r[srs_pkg::TX_PCS_DUR_LSB +: srs_pkg::TXRX_DUR_W], 2'h0});
               end
            end
            srs_pkg::TX_PCS: begin
               if (tx_cnt_r == 16'h0000) begin
                  tx_st_r <= srs_pkg::TX_IDLE;
               end else begin
                  tx_cnt_r <= tx_cnt_r - 16'h0001;
               end
            end
            default: tx_st_r <= srs_pkg::TX_HOLD;
         endcase
      end
   end

   // Completion flags are registered so they only move on mclk edges
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_reset_complete        <= 1'b0;
         tx_analog_reset_complete <= 1'b0;
      end else begin
         tx_reset_complete        <= (tx_st_r == srs_pkg::TX_IDLE) && !tx_any_s;
         if (!ovrd_s && (full_s || pma_s)) begin
            tx_analog_reset_complete <= 1'b0;
         end else if (tx_st_r == srs_pkg::TX_PMA && tx_cnt_r == 16'h0000) begin
            tx_analog_reset_complete <= 1'b1;
         end
      end
   end

   // Mode is caught when the rx request is seen; single mode stops after pma
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_st_r     <= srs_pkg::RX_HOLD;
         rx_single_r <= 1'b0;
         rx_cnt_r    <= 16'h0000;
      end else if (rxr_s && !ovrd_s) begin
         rx_st_r     <= srs_pkg::RX_HOLD;
         rx_single_r <= single_s;
         rx_cnt_r    <= 16'h0000;
      end else begin
         unique case (rx_st_r)
            srs_pkg::RX_IDLE: rx_st_r <= srs_pkg::RX_IDLE;
            srs_pkg::RX_HOLD: begin
               rx_st_r  <= srs_pkg::RX_PMA;
               rx_cnt_r <= 16'({tx_cfg_r[srs_pkg::RX_DUR_LSB +: srs_pkg::TXRX_DUR_W], 2'h0});
            end
            srs_pkg::RX_PMA: begin
               if (rx_cnt_r != 16'h0000) begin
                  rx_cnt_r <= rx_cnt_r - 16'h0001;
               end else if (rx_single_r) begin
                  rx_st_r <= srs_pkg::RX_IDLE;
               end else begin
                  rx_st_r  <= srs_pkg::RX_PCS;
                  rx_cnt_r <= 16'({tx_cfg_r[srs_pkg::RX_DUR_LSB +: srs_pkg::TXRX_DUR_W], 2'h0});
               end
            end
            srs_pkg::RX_PCS: begin
               if (rx_cnt_r == 16'h0000) begin
                  rx_st_r <= srs_pkg::RX_IDLE;
               end else begin
                  rx_cnt_r <= rx_cnt_r - 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_reset_complete <= 1'b0;
      end else begin
         rx_reset_complete <= (rx_st_r == srs_pkg::RX_IDLE) && !(rxr_s && !ovrd_s);
      end
   end

   property p_tx_hold;
      @(posedge mclk) disable iff (!rst_b)
      tx_any_s |=> tx_st_r == srs_pkg::TX_HOLD;
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("tx sequencer left hold while reset high");

   property p_tx_done_low;
      @(posedge mclk) disable iff (!rst_b)
      (full_s && !ovrd_s) |=> !tx_reset_complete;
   endproperty
   a_tx_done_low: assert property (p_tx_done_low)
      else $error("tx reset complete high during full reset");

   property p_tx_wait_ready;
      @(posedge mclk) disable iff (!rst_b)
      (tx_st_r == srs_pkg::TX_WRDY && !rdy_s && !tx_any_s) |=> tx_st_r == srs_pkg::TX_WRDY;
   endproperty
   a_tx_wait_ready: assert property (p_tx_wait_ready)
      else $error("tx pcs reset started without user ready");

   property p_tx_done_after_pcs;
      @(posedge mclk) disable iff (!rst_b)
      $rose(tx_reset_complete) |-> $past(tx_st_r, 2) inside {srs_pkg::TX_PCS, srs_pkg::TX_IDLE};
   endproperty
   a_tx_done_after_pcs: assert property (p_tx_done_after_pcs)
      else $error("tx reset complete rose outside pcs end");

   property p_tx_analog_low;
      @(posedge mclk) disable iff (!rst_b)
      (pma_s && !ovrd_s) |=> !tx_analog_reset_complete ##1 !tx_reset_complete;
   endproperty
   a_tx_analog_low: assert property (p_tx_analog_low)
      else $error("analog complete not low on analog reset");

   property p_tx_pcs_only;
      @(posedge mclk) disable iff (!rst_b)
      (tx_st_r == srs_pkg::TX_HOLD && tx_from_pcs_r && !tx_any_s) |=> tx_st_r == srs_pkg::TX_WRDY;
   endproperty
   a_tx_pcs_only: assert property (p_tx_pcs_only)
      else $error("coding reset entered pma phase");

   property p_rx_single;
      @(posedge mclk) disable iff (!rst_b)
      (rx_st_r == srs_pkg::RX_PMA && rx_cnt_r == 16'h0000 && rx_single_r && !rxr_s)
         |=> rx_st_r == srs_pkg::RX_IDLE ##1 rx_reset_complete;
   endproperty
   a_rx_single: assert property (p_rx_single)
      else $error("rx single mode did not stop after pma");

   property p_bvalid_hold;
      @(posedge mclk) disable iff (!rst_b)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold)
      else $error("write response dropped before bready");
endmodule

//--- verification/srs_fabric_model.sv
`timescale 1ns/10ps
module srs_fabric_model (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic hold,
   input  wire logic slow,
   output logic      tx_user_ready
);
   logic [5:0] cnt_r;
   // Ready comes only after a settle delay, standing in for user clocks coming up
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 6'h00;
         tx_user_ready <= 1'b0;
      end else if (hold) begin
         cnt_r <= 6'h00;
         tx_user_ready <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 6'h01;
         if (cnt_r >= (slow ? 6'h28 : 6'h02)) begin
            tx_user_ready <= 1'b1;
         end
      end
   end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, sel, ovr, hold, slow, rdy;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [6:0]  rq;
   logic [2:0]  en;
   wire  [5:0]  st;
   wire  [3:0]  hs;
   int          bad_count, num_checks;

   srs_sequencer dut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .channel_pll_reset(rq[0]),
      .channel_pll_lock_detect_en(en[0]), .channel_pll_locked(st[0]), .quad_pll_a_reset(rq[1]),
      .quad_pll_a_lock_detect_en(en[1]), .quad_pll_a_locked(st[1]), .quad_pll_b_reset(rq[2]),
      .quad_pll_b_lock_detect_en(en[2]), .quad_pll_b_locked(st[2]), .reset_sequence_select(sel),
      .reset_override(ovr), .tx_full_reset(rq[3]), .tx_analog_region_reset(rq[4]),
      .tx_coding_region_reset(rq[5]), .tx_user_ready(rdy), .tx_reset_complete(st[3]),
      .tx_analog_reset_complete(st[4]), .rx_full_reset(rq[6]), .rx_reset_complete(st[5]));
   srs_fabric_model fab (.mclk(mclk), .rst_b(rst_b), .hold(hold), .slow(slow), .tx_user_ready(rdy));
   // Handshake flags by index, so one wait task serves every channel
   assign hs = {rvalid, arready, bvalid, awready};

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic to();
      bad_count++;
      end_of_test();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Bounded handshake wait; the value is read before the edge's own updates land
   task automatic wt(input int k);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hs[k] !== 1'b1 && n < 50);
      if (hs[k] !== 1'b1) to();
   endtask
   task automatic wait_st(input int i, input logic v, input int max, output int n);
      n = 0;
      while (st[i] !== v) begin
         @(posedge mclk);
         n++;
         if (n > max) to();
      end
   endtask
   // Five cycles high: longer than the two-flop input synchroniser
   task automatic pulse(input int i);
      @(posedge mclk);
      rq[i] <= 1'b1;
      cyc(5);
      rq[i] <= 1'b0;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge mclk);
      {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hf, 2'b11};
      wt(0);
      chk(32'(wready), 32'h1);
      {awvalid, wvalid, bready} <= 3'b001;
      wt(1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge mclk);
      {araddr, arvalid} <= {a, 1'b1};
      wt(2);
      {arvalid, rready} <= 2'b01;
      wt(3);
      rready <= 1'b0;
      chk(rdata, ed);
      chk(32'(rresp), 32'(er));
   endtask

   task automatic t_regs();
      axi_rd(srs_pkg::OFF_TX_CFG, 32'h00040404, srs_pkg::RESP_OKAY);
      axi_rd(srs_pkg::OFF_QPLLB_CFG, 32'(srs_pkg::PLL_DUR_RST), srs_pkg::RESP_OKAY);
      axi_wr(srs_pkg::OFF_CHANNEL_PLL_CFG, 32'hffffffff, srs_pkg::RESP_OKAY);
      axi_rd(srs_pkg::OFF_CHANNEL_PLL_CFG, 32'h000003ff, srs_pkg::RESP_OKAY);
      axi_wr(srs_pkg::OFF_CHANNEL_PLL_CFG, 32'(srs_pkg::PLL_DUR_RST), srs_pkg::RESP_OKAY);
      axi_wr(srs_pkg::OFF_STATUS, 32'h0, srs_pkg::RESP_SLVERR);
      axi_rd(8'h40, 32'h0, srs_pkg::RESP_SLVERR);
   endtask
   task automatic t_pll();
      int n;
      wait_st(2, 1'b1, 600, n);
      wait_st(0, 1'b1, 600, n);
      pulse(0);
      chk(32'(st[2:0]), 32'h6);
      wait_st(0, 1'b1, 600, n);
      chk(32'(n > 64), 32'h1);
      en[2] <= 1'b0;
      pulse(2);
      cyc(300);
      chk(32'(st[2:0]), 32'h3);
      en[2] <= 1'b1;
      wait_st(2, 1'b1, 600, n);
   endtask
   task automatic t_tx();
      int n;
      wait_st(3, 1'b1, 400, n);
      hold <= 1'b1;
      pulse(3);
      chk(32'(st[4:3]), 32'h0);
      wait_st(4, 1'b1, 200, n);
      cyc(60);
      chk(32'(st[3]), 32'h0);
      {slow, hold} <= 2'b10;
      wait_st(3, 1'b1, 300, n);
      chk(32'(n > 40), 32'h1);
      pulse(5);
      chk(32'(st[4]), 32'h1);
      wait_st(3, 1'b1, 300, n);
      pulse(4);
      chk(32'(st[4]), 32'h0);
      wait_st(3, 1'b1, 400, n);
      chk(32'(st[4]), 32'h1);
   endtask
   task automatic t_rx();
      int ns, nq;
      pulse(6);
      chk(32'(st[5]), 32'h0);
      wait_st(5, 1'b1, 300, nq);
      sel <= 1'b1;
      cyc(14);
      pulse(6);
      wait_st(5, 1'b1, 300, ns);
      chk(32'(ns < nq), 32'h1);
      {sel, ovr} <= 2'b01;
      cyc(14);
      pulse(3);
      chk(32'(st[4:3]), 32'h3);
   endtask

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, sel, ovr, hold, slow} = '0;
      {awaddr, araddr, wdata, wstrb, rq, bad_count, num_checks} = '0;
      en = 3'h7;
      rst_b = 1'b0;
      cyc(4);
      rst_b <= 1'b1;
      t_regs();
      t_pll();
      t_tx();
      t_rx();
      end_of_test();
   end
endmodule
